// file: rtl/cac_clamp_output.v
// clamp loop, gain code and output stage of one front-end channel
// assumes registers written by a word port, converter word on clk_in
`timescale 1ns/1ns
`include "cac_consts.vh"
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - sampling edges of both sample clocks follow the placement register at 0x63.
// - gain code is nine bits, every value 0 to 511 accepted.
// - gain in dB equals code times 0.035.
// - during clamp pulse each converter word is compared with black reference.
// - black reference is eight bits, 0 to 255 in 256 steps.
// - error is low-pass filtered and drives the offset correction converter.
// - correction updates during each clamp pulse, however often it comes.
// - operating mode bit D2 set stops all clamp feedback updates.
// - with loop off, black level still applied as fixed offset.
// - output words latched at edge chosen by output phase register.
// - control bit D4 set makes output latches transparent.
// - control bit D3 set three-states the data outputs.
// - output is straight binary, Gray code when control bit D5 set.
module cac_clamp_output
#(
  parameter DATA_W = 12,
  parameter CORR_W = 12
)
(
  input  wire                    clk_in,
  input  wire                    rst_in,
  input  wire                    reg_wr_in,
  input  wire                    reg_rd_in,
  input  wire [`CAC_ADDR_W-1:0]  reg_addr_in,
  input  wire [`CAC_SAMP_W-1:0]  reg_wdata_in,
  output reg  [`CAC_SAMP_W-1:0]  reg_rdata_out,
  input  wire                    black_clamp_pulse_in,
  input  wire [DATA_W-1:0]       adc_word_in,
  output reg  [`CAC_SAMP_W-1:0]  sampling_edge_placement_out,
  output reg  [`CAC_GAIN_W-1:0]  amplifier_gain_code_out,
  output reg  [15:0]             gain_mdb_out,
  output reg  [CORR_W-1:0]       clamp_dac_out,
  output reg  [DATA_W-1:0]       data_out,
  output wire [DATA_W-1:0]       data_oe_n_out
);

////////////////////////////////////////////////////////////////////////////////
reg [`CAC_GAIN_W-1:0]  gain_code;
reg [7:0]              clamp_level;
reg [7:0]              operating_mode_register;
reg [7:0]              afe_ctrl;
reg [`CAC_PHASE_W-1:0] output_latch_phase;
reg [`CAC_PHASE_W-1:0] phase_cnt;
reg [CORR_W+`CAC_FILT_SHIFT-1:0] filt_acc;
reg                    clamp_seen;
reg [DATA_W-1:0]       latched_word;

function [DATA_W-1:0] to_gray;
  input [DATA_W-1:0] b;
  begin
    to_gray = b ^ (b >> 1);
  end
endfunction

wire clamp_off = operating_mode_register[`CAC_OPR_CLAMP_OFF];
wire signed [DATA_W+1:0] clamp_err =
  $signed({2'b00, clamp_level, {(DATA_W-8){1'b0}}} >> (DATA_W-8)) -
  $signed({2'b00, adc_word_in});

////////////////////////////////////////////////////////////////////////////////
// register port
always @(posedge clk_in or posedge rst_in)
begin
  if (rst_in)
  begin
    sampling_edge_placement_out <= `CAC_SAMP_RST;
    gain_code <= `CAC_GAIN_RST;
    clamp_level <= `CAC_CLAMP_RST;
    operating_mode_register <= `CAC_OP_MODE_RST;
    afe_ctrl <= `CAC_AFE_CTRL_RST;
    output_latch_phase <= {`CAC_PHASE_W{1'b0}};
  end
  else if (reg_wr_in)
  begin
    case (reg_addr_in)
      `CAC_ADDR_SAMP:      sampling_edge_placement_out <= reg_wdata_in;
      `CAC_ADDR_GAIN:      gain_code <= reg_wdata_in[`CAC_GAIN_W-1:0];
      `CAC_ADDR_CLAMP_LVL: clamp_level <= reg_wdata_in[7:0];
      `CAC_ADDR_OP_MODE:   operating_mode_register <= reg_wdata_in[7:0];
      `CAC_ADDR_AFE_CTRL:  afe_ctrl <= reg_wdata_in[7:0];
      `CAC_ADDR_OUT_PHASE: output_latch_phase <= reg_wdata_in[`CAC_PHASE_W-1:0];
      default:             ;
    endcase
  end
end

always @(posedge clk_in or posedge rst_in)
begin
  if (rst_in)
    reg_rdata_out <= {`CAC_SAMP_W{1'b0}};
  else if (reg_rd_in)
  begin
    case (reg_addr_in)
      `CAC_ADDR_SAMP:      reg_rdata_out <= sampling_edge_placement_out;
      `CAC_ADDR_GAIN:      reg_rdata_out <= {15'h0000, gain_code};
      `CAC_ADDR_CLAMP_LVL: reg_rdata_out <= {16'h0000, clamp_level};
      `CAC_ADDR_OP_MODE:   reg_rdata_out <= {16'h0000, operating_mode_register};
      `CAC_ADDR_AFE_CTRL:  reg_rdata_out <= {16'h0000, afe_ctrl};
      `CAC_ADDR_OUT_PHASE: reg_rdata_out <= {20'h00000, output_latch_phase};
      `CAC_ADDR_STATUS:    reg_rdata_out <= {{(`CAC_SAMP_W-CORR_W-1){1'b0}}, clamp_seen, clamp_dac_out};
      default:             reg_rdata_out <= {`CAC_SAMP_W{1'b0}};
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// gain: millidecibels = code * 35
always @(posedge clk_in or posedge rst_in)
begin
  if (rst_in)
  begin
    amplifier_gain_code_out <= `CAC_GAIN_RST;
    gain_mdb_out <= 16'h0000;
  end
  else
  begin
    amplifier_gain_code_out <= gain_code;
    // product fits: 511 * 35 stays below 16 bits
    gain_mdb_out <= gain_code * `CAC_GAIN_STEP_W'd`CAC_GAIN_STEP_MDB;
  end
end

////////////////////////////////////////////////////////////////////////////////
// clamp loop: first-order filter, one step per clamp-active word
always @(posedge clk_in or posedge rst_in)
begin
  if (rst_in)
  begin
    filt_acc <= {(CORR_W+`CAC_FILT_SHIFT){1'b0}};
    clamp_dac_out <= {CORR_W{1'b0}};
    clamp_seen <= 1'b0;
  end
  else
  begin
    if (black_clamp_pulse_in && !clamp_off)
    begin
      filt_acc <= filt_acc + {{(CORR_W+`CAC_FILT_SHIFT-DATA_W-2){clamp_err[DATA_W+1]}}, clamp_err};
      clamp_seen <= 1'b1;
    end
    if (clamp_off)
      clamp_dac_out <= {{(CORR_W-8){1'b0}}, clamp_level};
    else
      clamp_dac_out <= filt_acc[CORR_W+`CAC_FILT_SHIFT-1:`CAC_FILT_SHIFT];
  end
end

////////////////////////////////////////////////////////////////////////////////
// output stage: latch once per phase period at programmed phase
always @(posedge clk_in or posedge rst_in)
begin
  if (rst_in)
  begin
    phase_cnt <= {`CAC_PHASE_W{1'b0}};
    latched_word <= {DATA_W{1'b0}};
    data_out <= {DATA_W{1'b0}};
  end
  else
  begin
    phase_cnt <= phase_cnt + 1'b1;
    if (phase_cnt == output_latch_phase)
      latched_word <= adc_word_in;
    if (afe_ctrl[`CAC_AFE_TRANSP])
      data_out <= afe_ctrl[`CAC_AFE_GRAY] ? to_gray(adc_word_in) : adc_word_in;
    else
      data_out <= afe_ctrl[`CAC_AFE_GRAY] ? to_gray(latched_word) : latched_word;
  end
end

assign data_oe_n_out = {DATA_W{afe_ctrl[`CAC_AFE_TRISTATE]}};

endmodule // cac_clamp_output

// file: rtl/cac_consts.vh
// constants for the clamp and output control block
// assumes inclusion by rtl/cac_clamp_output.v only
`ifndef CAC_CONSTS_VH
`define CAC_CONSTS_VH
`define CAC_ADDR_W          8
`define CAC_ADDR_SAMP       8'h63
`define CAC_ADDR_GAIN       8'h64
`define CAC_ADDR_CLAMP_LVL  8'h65
`define CAC_ADDR_OP_MODE    8'h66
`define CAC_ADDR_AFE_CTRL   8'h67
`define CAC_ADDR_OUT_PHASE  8'h68
`define CAC_ADDR_STATUS     8'h69
`define CAC_SAMP_W          24
`define CAC_SAMP_RST        24'h000000
`define CAC_GAIN_W          9
`define CAC_GAIN_RST        9'h000
`define CAC_GAIN_STEP_MDB   35
`define CAC_CLAMP_RST       8'h00
`define CAC_OP_MODE_RST     8'h00
`define CAC_AFE_CTRL_RST    8'h00
`define CAC_GAIN_STEP_W     16
`define CAC_OPR_CLAMP_OFF   2
`define CAC_AFE_TRANSP      4
`define CAC_AFE_TRISTATE    3
`define CAC_AFE_GRAY        5
`define CAC_FILT_SHIFT      4
`define CAC_PHASE_W         4
`endif

// file: sim/cac_asic_sink.sv
// sink: receiver taking the output words each clock
// assumes oe_n low means the bus is driven
`timescale 1ns/1ns
module cac_asic_sink (
  input  wire logic        clk_in,
  input  wire logic [11:0] data_in,
  input  wire logic [11:0] oe_n_in,
  output logic      [11:0] word_out
);
  // released bits flip, never hold
  always @(posedge clk_in) word_out <= (data_in & ~oe_n_in) | (~word_out & oe_n_in);
endmodule // cac_asic_sink

// file: sim/cac_props_properties.sv
// checker: port assertions of the clamp and output block
// assumes binding onto cac_clamp_output
`timescale 1ns/1ns
module cac_props #(parameter DATA_W = 12) (
  input wire logic              clk_in,
  input wire logic              rst_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [7:0]        reg_addr_in,
  input wire logic [23:0]       reg_wdata_in,
  input wire logic [23:0]       reg_rdata_out,
  input wire logic              black_clamp_pulse_in,
  input wire logic [23:0]       sampling_edge_placement_out,
  input wire logic [8:0]        amplifier_gain_code_out,
  input wire logic [15:0]       gain_mdb_out,
  input wire logic [11:0]       clamp_dac_out,
  input wire logic [DATA_W-1:0] data_oe_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_samp_write:
  assert property (reg_wr_in && reg_addr_in == 8'h63 |=> sampling_edge_placement_out == $past(reg_wdata_in))
    else $error("placement wrong");
  a_gain_write:
  assert property (reg_wr_in && reg_addr_in == 8'h64 |-> ##2 amplifier_gain_code_out == $past(reg_wdata_in[8:0], 2))
    else $error("gain wrong");
  a_gain_db_map:
  assert property (gain_mdb_out == amplifier_gain_code_out * 16'd35)
    else $error("gain db wrong");
  a_gain_rd_width:
  assert property (reg_rd_in && reg_addr_in == 8'h64 |=> reg_rdata_out[23:9] == 15'h0000)
    else $error("gain read wide");
  a_level_rd_width:
  assert property (reg_rd_in && reg_addr_in == 8'h65 |=> reg_rdata_out[23:8] == 16'h0000)
    else $error("level read wide");
  a_out_tristate:
  assert property (reg_wr_in && reg_addr_in == 8'h67 |=> data_oe_n_out == {DATA_W{$past(reg_wdata_in[3])}})
    else $error("enable wrong");
  a_clamp_hold:
  assert property ((!black_clamp_pulse_in && !reg_wr_in)[*3] |=> $stable(clamp_dac_out))
    else $error("correction moved");
  a_clamp_fixed:
  assert property (reg_wr_in && reg_addr_in == 8'h65 ##1 reg_wr_in && reg_addr_in == 8'h66 && reg_wdata_in[2]
    |-> ##2 clamp_dac_out == {4'h0, $past(reg_wdata_in[7:0], 3)}) else $error("offset wrong");
endmodule // cac_props
bind cac_clamp_output cac_props #(.DATA_W(DATA_W)) u_props (.*);

// file: sim/testbench.sv
// testbench: random and corner stimulus for the clamp and output block
// assumes the design, the sink and the checker are compiled first
`timescale 1ns/1ns
module testbench;
  logic        clk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, black_clamp_pulse_in = 0;
  logic [7:0]  reg_addr_in = 0;
  logic [23:0] reg_wdata_in = 0, reg_rdata_out, sampling_edge_placement_out, q, p;
  logic [11:0] adc_word_in = 0, data_out, data_oe_n_out, clamp_dac_out, seen, x;
  logic [8:0]  amplifier_gain_code_out;
  logic [15:0] gain_mdb_out;
  int          bad_count = 0, cmp_count = 0, i;
  initial forever #10 clk_in = ~clk_in;
  cac_clamp_output DUT (.*);
  cac_asic_sink u_sink (.clk_in(clk_in), .data_in(data_out), .oe_n_in(data_oe_n_out), .word_out(seen));
  ////////////////////////////////////////
  function automatic logic [11:0] gry(input logic [11:0] b);
    return b ^ (b >> 1);
  endfunction
  task automatic chk(input logic [23:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in) {reg_wr_in, reg_rd_in} <= 2'b00;
  endtask
  task automatic w(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk_in) {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} <= {2'b10, a, d};
  endtask
  task automatic r(input logic [7:0] a);
    @(posedge clk_in) {reg_wr_in, reg_rd_in, reg_addr_in} <= {2'b01, a};
    idle(1);
    @(negedge clk_in) q = reg_rdata_out;
  endtask
  task automatic pulse(input logic [11:0] a);
    @(posedge clk_in) {black_clamp_pulse_in, adc_word_in} <= {1'b1, a};
    repeat (20) @(posedge clk_in);
    black_clamp_pulse_in <= 0;
    idle(3);
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    i = $urandom(32'hFA57A5DA);
    repeat (3) @(posedge clk_in);
    rst_in <= 0;
    for (i = 0; i < 16; i++)
    begin
      x = (i < 2) ? i * 511 : $urandom % 512;
      p = $urandom;
      w(8'h64, x);
      w(8'h63, p);
      w(8'h67, i[1:0] << 4);
      adc_word_in <= x;
      idle(20);
      chk(amplifier_gain_code_out, x);
      chk(gain_mdb_out, x * 35);
      chk(seen, i[1] ? gry(x) : x);
      r(8'h63);
      chk(q, p);
      chk(sampling_edge_placement_out, p);
      r(8'h65 + i[2:0] * 8'h11);
      chk(q, 0);
    end
    w(8'h67, 8);
    idle(2);
    chk(data_oe_n_out, 12'hFFF);
    w(8'h66, 0);
    w(8'h65, 200);
    r(8'h65);
    chk(q, 200);
    x = $urandom % 100;
    pulse(x);
    chk(clamp_dac_out, (20 * (200 - x)) >> 4);
    w(8'h65, 8'h9C);
    w(8'h66, 4);
    pulse($urandom);
    chk(clamp_dac_out, 8'h9C);
    final_report();
  end
endmodule // testbench
